// >>> design/anpr_defines.vh
`ifndef ANPR_DEFINES_VH
`define ANPR_DEFINES_VH
// ************************************************************
// Register addresses (5-bit management register numbers)
// ************************************************************
`define ANPR_ADDR_PARTNER_ABILITY 5'h05
`define ANPR_ADDR_EXPANSION       5'h06
`define ANPR_ADDR_NP_TX           5'h07
`define ANPR_ADDR_NP_PARTNER      5'h08
// ************************************************************
// Field positions of a link control word
// ************************************************************
`define ANPR_BIT_MORE_PAGES       15
`define ANPR_BIT_RSVD             14
`define ANPR_BIT_PAGE_TYPE        13
`define ANPR_BIT_SECOND_ACK       12
`define ANPR_BIT_TOGGLE           11
`define ANPR_CODE_MSB             10
// Expansion register bits
`define ANPR_BIT_PAGE_RCVD        1
`define ANPR_BIT_NP_ABLE          2
`define ANPR_BIT_LP_NP_ABLE       3
// ************************************************************
// Reset values
// ************************************************************
`define ANPR_NP_TX_RESET          16'h2001
`define ANPR_NP_PARTNER_RESET     16'h0000
`define ANPR_PARTNER_RESET        16'h0000
`endif

// >>> design/anpr_toggle.v
`timescale 1ns/1ps
`default_nettype none
`include "anpr_defines.vh"
// Toggle flag generator for outgoing next pages
module anpr_toggle (
	input  wire        clk,
	input  wire        rst,
	input  wire        base_sent,
	input  wire        base_bit11,
	input  wire        np_sent,
	output reg         toggle_q
);
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			toggle_q <= 1'b0;
		end else if (base_sent) begin
			// First next page carries inverse of base bit 11
			toggle_q <= ~base_bit11;
		end else if (np_sent) begin
			toggle_q <= ~toggle_q;
		end
	end
endmodule
`default_nettype wire

// >>> design/anpr_rx_capture.v
`timescale 1ns/1ps
`default_nettype none
`include "anpr_defines.vh"
// Stores received words and keeps the latched page-received flag
module anpr_rx_capture (
	input  wire        clk,
	input  wire        rst,
	input  wire        rx_valid,
	input  wire        rx_is_np,
	input  wire [15:0] rx_word,
	input  wire        exp_read,
	output reg  [15:0] partner_q,
	output reg  [15:0] np_partner_q,
	output reg         page_rcvd_q
);
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			partner_q    <= `ANPR_PARTNER_RESET;
			np_partner_q <= `ANPR_NP_PARTNER_RESET;
			page_rcvd_q  <= 1'b0;
		end else begin
			if (rx_valid) begin
				partner_q <= rx_word;
				if (rx_is_np) begin
					np_partner_q <= rx_word;
				end
			end
			// Set wins over clear-on-read so no page is missed
			if (rx_valid) begin
				page_rcvd_q <= 1'b1;
			end else if (exp_read) begin
				page_rcvd_q <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// >>> design/anpr_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "anpr_defines.vh"
module anpr_regs (
	input  wire        clk,
	input  wire        rst,
	input  wire        mgmt_wr,
	input  wire        mgmt_rd,
	input  wire [4:0]  mgmt_addr,
	input  wire [15:0] mgmt_wdata,
	output reg  [15:0] mgmt_rdata,
	input  wire        base_sent,
	input  wire        base_bit11,
	input  wire        np_sent,
	input  wire        rx_valid,
	input  wire        rx_is_np,
	input  wire [15:0] rx_word,
	input  wire        lp_np_able,
	output reg  [15:0] np_tx_word,
	output reg         np_tx_enable
);
	// ************************************************************
	// Transmit register: writable fields
	// ************************************************************
	reg         more_pages_flag_q;
	reg         page_type_flag_q;
	reg         second_acknowledge_q;
	reg  [10:0] code_q;
	wire        toggle_q;
	wire [15:0] partner_q;
	wire [15:0] np_partner_q;
	wire        page_rcvd_q;
	wire        exp_read;
	wire [15:0] tx_view;
	wire [15:0] np_partner_view;
	wire [15:0] exp_view;
	reg  [15:0] rdata_d;

	// Reset word kept whole so each field takes its own slice of it
	localparam [15:0] TX_RST = `ANPR_NP_TX_RESET;

	function is_addr;
		input [4:0] a;
		input [4:0] b;
		begin
			is_addr = (a == b);
		end
	endfunction

	assign exp_read = mgmt_rd && is_addr(mgmt_addr, `ANPR_ADDR_EXPANSION);

	// Toggle and reserved bits ignore writes; software cannot corrupt
	// the alternation sequence with a stale value
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			more_pages_flag_q    <= TX_RST[`ANPR_BIT_MORE_PAGES];
			page_type_flag_q     <= TX_RST[`ANPR_BIT_PAGE_TYPE];
			second_acknowledge_q <= TX_RST[`ANPR_BIT_SECOND_ACK];
			code_q               <= TX_RST[`ANPR_CODE_MSB:0];
		end else if (mgmt_wr && is_addr(mgmt_addr, `ANPR_ADDR_NP_TX)) begin
			more_pages_flag_q    <= mgmt_wdata[`ANPR_BIT_MORE_PAGES];
			page_type_flag_q     <= mgmt_wdata[`ANPR_BIT_PAGE_TYPE];
			second_acknowledge_q <= mgmt_wdata[`ANPR_BIT_SECOND_ACK];
			code_q               <= mgmt_wdata[`ANPR_CODE_MSB:0];
		end
	end

	anpr_toggle u_toggle (
		.clk        (clk),
		.rst        (rst),
		.base_sent  (base_sent),
		.base_bit11 (base_bit11),
		.np_sent    (np_sent),
		.toggle_q   (toggle_q)
	);

	anpr_rx_capture u_rx (
		.clk          (clk),
		.rst          (rst),
		.rx_valid     (rx_valid),
		.rx_is_np     (rx_is_np),
		.rx_word      (rx_word),
		.exp_read     (exp_read),
		.partner_q    (partner_q),
		.np_partner_q (np_partner_q),
		.page_rcvd_q  (page_rcvd_q)
	);

	// ************************************************************
	// Read views
	// ************************************************************
	assign tx_view = {more_pages_flag_q,
		1'b0,
		page_type_flag_q,
		second_acknowledge_q,
		toggle_q,
		code_q};

	assign np_partner_view = {np_partner_q[`ANPR_BIT_MORE_PAGES],
		1'b0,
		np_partner_q[`ANPR_BIT_PAGE_TYPE],
		np_partner_q[`ANPR_BIT_SECOND_ACK],
		np_partner_q[`ANPR_BIT_TOGGLE],
		np_partner_q[`ANPR_CODE_MSB:0]};

	assign exp_view = {12'h000, lp_np_able, 1'b1, page_rcvd_q, 1'b0};

	always @* begin
		case (mgmt_addr)
		`ANPR_ADDR_PARTNER_ABILITY: rdata_d = partner_q;
		`ANPR_ADDR_EXPANSION:       rdata_d = exp_view;
		`ANPR_ADDR_NP_TX:           rdata_d = tx_view;
		`ANPR_ADDR_NP_PARTNER:      rdata_d = np_partner_view;
		default:                    rdata_d = 16'h0000;
		endcase
	end

	// ************************************************************
	// Registered outputs
	// ************************************************************
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			mgmt_rdata   <= 16'h0000;
			np_tx_word   <= `ANPR_NP_TX_RESET;
			np_tx_enable <= 1'b0;
		end else begin
			mgmt_rdata   <= rdata_d;
			np_tx_word   <= tx_view;
			// Local next pages only while partner is next-page able
			np_tx_enable <= lp_np_able;
		end
	end
endmodule
`default_nettype wire

// >>> tb/anpr_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checker
// ****
module anpr_chk (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        mgmt_wr,
	input wire logic        mgmt_rd,
	input wire logic [4:0]  mgmt_addr,
	input wire logic [15:0] mgmt_wdata,
	input wire logic [15:0] mgmt_rdata,
	input wire logic        base_sent,
	input wire logic        base_bit11,
	input wire logic        np_sent,
	input wire logic        rx_valid,
	input wire logic        rx_is_np,
	input wire logic [15:0] rx_word,
	input wire logic        lp_np_able,
	input wire logic [15:0] np_tx_word,
	input wire logic        np_tx_enable
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_wr7; mgmt_wr && mgmt_addr == 5'h07; endsequence
	sequence s_quiet; !np_sent && !base_sent; endsequence
	sequence s_np_once;
		s_quiet ##1 np_sent && !base_sent ##1 s_quiet;
	endsequence
	sequence s_np_rx;
		rx_valid && rx_is_np ##1 !rx_valid ##1 mgmt_addr == 5'h08;
	endsequence
	a_tx_enable: assert property (
		!$past(rst) |-> np_tx_enable == $past(lp_np_able)) else $error("enable");
	a_rsvd_tx: assert property (!np_tx_word[14]) else $error("rsvd tx");
	a_rsvd_read: assert property (
		mgmt_addr inside {5'h07, 5'h08} |=> !mgmt_rdata[14]) else $error("rsvd");
	a_toggle_first: assert property (
		base_sent |-> ##2 np_tx_word[11] == !$past(base_bit11, 2))
		else $error("first toggle");
	a_toggle_flip: assert property (
		s_np_once |=> np_tx_word[11] != $past(np_tx_word[11], 2))
		else $error("toggle flip");
	a_write_fields: assert property (
		s_wr7 |-> ##2 (np_tx_word & 16'hb7ff) == ($past(mgmt_wdata, 2) & 16'hb7ff))
		else $error("tx fields");
	a_np_read: assert property (
		s_np_rx |=> mgmt_rdata == ($past(rx_word, 3) & 16'hbfff))
		else $error("partner word");
	a_rcvd_clear: assert property (
		mgmt_rd && mgmt_addr == 5'h06 && !rx_valid ##1 mgmt_addr == 5'h06
		|=> !mgmt_rdata[1]) else $error("rcvd clear");
endmodule
bind anpr_regs anpr_chk chk_u (.*);
`default_nettype wire

// >>> tb/anpr_lp_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Remote link partner
// ****
module anpr_lp_model (
	input  wire logic        clk,
	input  wire logic        lp_go,
	input  wire logic        lp_np,
	input  wire logic [15:0] lp_w,
	output var  logic        rx_valid,
	output var  logic        rx_is_np,
	output var  logic [15:0] rx_word
);
	initial {rx_valid, rx_is_np, rx_word} = 18'h00000;
	always @(posedge clk) begin
		rx_valid <= lp_go;
		rx_is_np <= lp_np;
		// Idle word flips so stale data never passes as a fresh page
		rx_word <= lp_go ? lp_w : ~rx_word;
	end
endmodule
`default_nettype wire

// >>> tb/anpr_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Bench
// ****
module anpr_regs_tb_top;
	logic        clk, rst, mgmt_wr, mgmt_rd, base_sent, base_bit11, np_sent;
	logic        rx_valid, rx_is_np, lp_np_able, np_tx_enable, lp_go, lp_np;
	logic [4:0]  mgmt_addr;
	logic [15:0] mgmt_wdata, mgmt_rdata, rx_word, np_tx_word, lp_w, d;
	int          fails, check_count;
	anpr_regs dut_u (.*);
	anpr_lp_model lp_u (.*);
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task chk(string n, logic [15:0] e, logic [15:0] g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	task wr(logic [4:0] a, logic [15:0] v);
		@(posedge clk);
		mgmt_wr <= 1'b1;
		mgmt_addr <= a;
		mgmt_wdata <= v;
		@(posedge clk) mgmt_wr <= 1'b0;
	endtask
	task rd(logic [4:0] a);
		@(posedge clk);
		mgmt_rd <= 1'b1;
		mgmt_addr <= a;
		@(posedge clk) mgmt_rd <= 1'b0;
		#1 d = mgmt_rdata;
	endtask
	task conclude;
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		conclude;
	end
	initial begin
		{rst, mgmt_wr, mgmt_rd, base_sent, base_bit11, np_sent} = 6'h20;
		{lp_np_able, lp_go, lp_np, mgmt_addr, mgmt_wdata, lp_w} = 40'h0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rd(5'h07);
		chk("reg7 reset", 16'h2001, d);
		for (int i = 0; i < 2; i++) begin
			wr(5'h07, i ? 16'h0000 : 16'hbfff);
			rd(5'h07);
			chk("reg7", i ? 16'h0000 : 16'hb7ff, d);
			chk("tx", i ? 16'h0000 : 16'hb7ff, np_tx_word);
		end
		wr(5'h08, 16'h1234);
		rd(5'h08);
		chk("reg8 ro", 16'h0000, d);
		rd(5'h1f);
		chk("unmapped", 16'h0000, d);
		@(posedge clk) base_sent <= 1'b1;
		@(posedge clk) base_sent <= 1'b0;
		rd(5'h07);
		chk("toggle0", 16'h0800, d);
		for (int i = 0; i < 2; i++) begin
			@(posedge clk) np_sent <= 1'b1;
			@(posedge clk) np_sent <= 1'b0;
			rd(5'h07);
			chk("toggle", i ? 16'h0800 : 16'h0000, d);
		end
		@(posedge clk) lp_np_able <= 1'b1;
		repeat (2) @(posedge clk);
		#1 chk("enable", 16'h0001, {15'h0000, np_tx_enable});
		@(posedge clk);
		lp_w <= 16'hf8a5;
		lp_np <= 1'b1;
		lp_go <= 1'b1;
		@(posedge clk) lp_go <= 1'b0;
		rd(5'h08);
		chk("partner", 16'hb8a5, d);
		rd(5'h05);
		chk("ability", 16'hf8a5, d);
		rd(5'h06);
		chk("rcvd", 16'h000e, d & 16'h000e);
		rd(5'h06);
		chk("rcvd clr", 16'h000c, d & 16'h000e);
		conclude;
	end
endmodule
`default_nettype wire
